// *** dmac_arb.sv ***
// fixed-priority channel arbiter, lowest number wins
`timescale 1ns/1ps
module dmac_arb
  import dmac_pkg::*;
#(
  parameter int N = DMAC_NCH
)
(
  input wire logic [N-1:0] req,
  output logic gnt_valid,
  output logic [1:0] gnt_idx
);
  always_comb
  begin
    gnt_valid = 1'b0;
    gnt_idx = 2'h0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        gnt_valid = 1'b1;
        gnt_idx = 2'(i);
      end
    end
  end
endmodule

// *** dmac_mem_model.sv ***
// bus partner: shared sram and peripheral bus with a programmable stall
`timescale 1ns/1ps
module dmac_mem_model
  import dmac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_periph,
  input wire logic mem_byte,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0] stall,
  output logic mem_gnt,
  output logic [15:0] mem_rdata
);
  logic [3:0] waited;
  logic [15:0] noise;
  logic [41:0] wq[$];
  // the cpu owns the bus for stall cycles before each grant
  assign mem_gnt = mem_req && (waited == stall);
  // noise outside a grant so a stale sample never looks right
  assign mem_rdata = mem_gnt ? (mem_addr[15:0] ^ 16'ha5c3) : noise;
  always_ff @(posedge clk_sys)
  begin
    noise <= rstn ? noise + 16'h3b1 : 16'h1234;
    waited <= (rstn && mem_req && !mem_gnt) ? waited + 4'h1 : 4'h0;
    if (mem_gnt && mem_we)
      wq.push_back({mem_byte, mem_periph, mem_addr, mem_wdata});
  end
endmodule

// *** dmac_pkg.sv ***
// package: register map, fields and encodings of the four-channel dma controller
package dmac_pkg;
  localparam int DMAC_NCH = 4;
  // per-channel register index within an 8-word channel window (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_REQ = 3'h1;
  localparam logic [2:0] REG_STAL = 3'h2;
  localparam logic [2:0] REG_STAH = 3'h3;
  localparam logic [2:0] REG_STBL = 3'h4;
  localparam logic [2:0] REG_STBH = 3'h5;
  localparam logic [2:0] REG_PAD = 3'h6;
  localparam logic [2:0] REG_CNT = 3'h7;
  // common status registers, byte address (addr[7] == 1'b0 are channels 0..3 at 0x00..0x7f)
  localparam logic [7:0] ADDR_PWC = 8'h80;
  localparam logic [7:0] ADDR_RQC = 8'h84;
  localparam logic [7:0] ADDR_PPS = 8'h88;
  localparam logic [7:0] ADDR_LCA = 8'h8c;
  localparam logic [7:0] ADDR_DSADRL = 8'h90;
  localparam logic [7:0] ADDR_DSADRH = 8'h94;
  // channel_control fields
  localparam int CTRL_EN_BIT = 15;
  localparam int CTRL_SIZE_BIT = 14;
  localparam int CTRL_DIR_BIT = 13;
  localparam int CTRL_HALF_BIT = 12;
  localparam int CTRL_NULL_WRITE_SELECT_BIT = 11;
  localparam int CTRL_AMODE_LSB = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hf833;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // channel_request_select fields
  localparam int REQ_FORCE_BIT = 15;
  localparam logic [7:0] REQ_NUM_RESET = 8'h00;
  localparam int CNT_W = 14;
  localparam int ADDR_W = 24;
  localparam logic [3:0] LAST_CH_RESET = 4'hf;
  // addressing modes
  localparam logic [1:0] AMODE_POSTINC = 2'h0;
  localparam logic [1:0] AMODE_NOINC = 2'h1;
  localparam logic [1:0] AMODE_PERIPH = 2'h2;
  // operating mode bits: bit 0 one-shot, bit 1 ping-pong
  localparam int MODE_ONESHOT_BIT = 0;
  localparam int MODE_PINGPONG_BIT = 1;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_DONE = 4'b1000
  } dmac_state_t;
endpackage

// *** dmac_sync.sv ***
// two-flop synchroniser for a vector of peripheral request levels
`timescale 1ns/1ps
module dmac_sync
#(
  parameter int W = 8
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;
  always_comb
  begin
    next_meta = din;
    next_dout = meta;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule

// *** dmac_top.sv ***
// four-channel dma controller: registers, request logic, arbiter and bus engine
// Operation
// - four independent channels, each one direction
// - fixed priority picks; others stay pending
// - interrupt at half or full block
// - enable bit activates channel, resets zero
// - size bit: one byte, zero word
// - direction one: sram to peripheral
// - null write to peripheral beside sram write; only marked in null_wr_q, never issued
// - addressing mode: postinc, noinc, peripheral indirect
// - operating mode: continuous/one-shot, ping-pong
// - ping-pong alternates start address per block
// - one-shot ping-pong: one block each buffer
// - force bit starts one manual transfer
// - force cleared only by hardware
// - request number selects triggering source
// - sram access through shared arbiter, may stall
// - primary, secondary, peripheral address, count held
// - common collision, address, last channel status
// - block length is count plus one
// - force and peripheral request collide sets flag
// - last channel reads 1111 until transfer
// - ping-pong status one means secondary
`timescale 1ns/1ps
module dmac_top
  import dmac_pkg::*;
#(
  parameter int NSRC = 128
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [NSRC-1:0] periph_irq,
  input wire logic [NSRC-1:0] periph_wr_collision,
  input wire logic [ADDR_W-1:0] periph_indirect_addr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_periph,
  output logic mem_byte,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_gnt,
  input wire logic [15:0] mem_rdata,
  output logic [DMAC_NCH-1:0] channel_interrupt_flag
);
  logic [NSRC-1:0] irq_s;
  logic [NSRC-1:0] pwc_s;
  logic [15:0] ctrl [DMAC_NCH];
  logic [DMAC_NCH-1:0] force_bit;
  logic [7:0] request_number [DMAC_NCH];
  logic [ADDR_W-1:0] sta [DMAC_NCH];
  logic [ADDR_W-1:0] stb [DMAC_NCH];
  logic [15:0] pad [DMAC_NCH];
  logic [CNT_W-1:0] count_field [DMAC_NCH];
  logic [CNT_W-1:0] done_cnt [DMAC_NCH];
  logic [ADDR_W-1:0] offs [DMAC_NCH];
  logic [DMAC_NCH-1:0] pend;
  logic [DMAC_NCH-1:0] ping_pong_state;
  logic [DMAC_NCH-1:0] second_block;
  logic [DMAC_NCH-1:0] irq_prev;
  logic [DMAC_NCH-1:0] request_collision_flag;
  logic [DMAC_NCH-1:0] pwc_flag;
  logic [3:0] last_channel;
  logic [ADDR_W-1:0] recent_sram_address;
  dmac_state_t state;
  logic [1:0] cur;
  logic [15:0] data;
  logic [15:0] rdata_q;
  logic gnt_valid;
  logic [1:0] gnt_idx;
  logic [DMAC_NCH-1:0] next_pend;
  logic [DMAC_NCH-1:0] irq_lvl;
  logic [DMAC_NCH-1:0] pwc_lvl;

  dmac_sync #(.W(NSRC)) u_sync_irq (.clk_sys(clk_sys), .rstn(rstn), .din(periph_irq),
    .dout(irq_s));
  dmac_sync #(.W(NSRC)) u_sync_pwc (.clk_sys(clk_sys), .rstn(rstn), .din(periph_wr_collision),
    .dout(pwc_s));
  // no channel competes while a transfer is in flight; the active one finishes first
  dmac_arb #(.N(DMAC_NCH)) u_arb (.req(pend & ~{DMAC_NCH{state != ST_IDLE}}),
    .gnt_valid(gnt_valid), .gnt_idx(gnt_idx));

  function automatic logic [15:0] ch_read(input logic [2:0] idx, input int c);
    unique case (idx)
      REG_CTRL: ch_read = ctrl[c];
      REG_REQ: ch_read = {force_bit[c], 7'h00, request_number[c]};
      REG_STAL: ch_read = sta[c][15:0];
      REG_STAH: ch_read = {8'h00, sta[c][23:16]};
      REG_STBL: ch_read = stb[c][15:0];
      REG_STBH: ch_read = {8'h00, stb[c][23:16]};
      REG_PAD: ch_read = pad[c];
      REG_CNT: ch_read = {2'h0, count_field[c]};
    endcase
  endfunction

  // sram address of the current element: start buffer plus running offset, or periph_indirect_addr in peripheral indirect mode
  function automatic logic [ADDR_W-1:0] sram_addr(input int c);
    logic [ADDR_W-1:0] base;
    base = ping_pong_state[c] ? stb[c] : sta[c];
    if (ctrl[c][CTRL_AMODE_LSB+:2] == AMODE_PERIPH)
      sram_addr = periph_indirect_addr;
    else
      sram_addr = base + offs[c];
  endfunction

  // per-channel request detection
  always_comb
  begin
    for (int c = 0; c < DMAC_NCH; c++)
    begin
      irq_lvl[c] = irq_s[request_number[c][6:0]];
      pwc_lvl[c] = pwc_s[request_number[c][6:0]];
    end
  end

  always_comb
  begin
    next_pend = pend;
    for (int c = 0; c < DMAC_NCH; c++)
    begin
      if (ctrl[c][CTRL_EN_BIT] && irq_lvl[c] && !irq_prev[c])
        next_pend[c] = 1'b1;
      // a standing force only requests between transfers, else it would run twice
      if (ctrl[c][CTRL_EN_BIT] && force_bit[c] && state == ST_IDLE)
        next_pend[c] = 1'b1;
      if (!ctrl[c][CTRL_EN_BIT])
        next_pend[c] = 1'b0;
    end
    if (gnt_valid)
      next_pend[gnt_idx] = 1'b0;
  end

  // next-state of the bus engine
  dmac_state_t next_state;
  logic [1:0] next_cur;
  logic [15:0] next_data;
  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_data = data;
    unique case (state)
      ST_IDLE:
        if (gnt_valid)
        begin
          next_state = ST_READ;
          next_cur = gnt_idx;
        end
      ST_READ:
        if (mem_gnt)
        begin
          next_state = ST_WRITE;
          next_data = mem_rdata;
        end
      ST_WRITE:
        if (mem_gnt)
          next_state = ST_DONE;
      ST_DONE:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      cur <= 2'h0;
      data <= 16'h0000;
      pend <= '0;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      data <= next_data;
      pend <= next_pend;
    end
  end

  // bus outputs; read phase takes source, write phase the destination
  logic dir_ram;
  always_comb
  begin
    dir_ram = ctrl[cur][CTRL_DIR_BIT];
    mem_req = (state == ST_READ) || (state == ST_WRITE);
    mem_we = (state == ST_WRITE);
    mem_periph = (state == ST_READ) ? !dir_ram : dir_ram;
    mem_byte = ctrl[cur][CTRL_SIZE_BIT];
    mem_addr = mem_periph ? {8'h00, pad[cur]} : sram_addr(int'(cur));
    mem_wdata = data;
  end

  // register file, channel progress and status
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < DMAC_NCH; c++)
      begin
        ctrl[c] <= CTRL_RESET;
        request_number[c] <= REQ_NUM_RESET;
        sta[c] <= '0;
        stb[c] <= '0;
        pad[c] <= 16'h0000;
        count_field[c] <= '0;
        done_cnt[c] <= '0;
        offs[c] <= '0;
      end
      force_bit <= '0;
      ping_pong_state <= '0;
      second_block <= '0;
      irq_prev <= '0;
      request_collision_flag <= '0;
      pwc_flag <= '0;
      last_channel <= LAST_CH_RESET;
      recent_sram_address <= '0;
      channel_interrupt_flag <= '0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      // edge detect starts low like an idle request pin, so reset makes no request
      irq_prev <= irq_lvl;
      channel_interrupt_flag <= '0;
      rdata_q <= 16'h0000;
      if (reg_rd)
      begin
        if (reg_addr[7] == 1'b0)
          rdata_q <= ch_read(reg_addr[4:2], int'(reg_addr[6:5]));
        else if (reg_addr == ADDR_PWC)
          rdata_q <= {12'h000, pwc_flag};
        else if (reg_addr == ADDR_RQC)
          rdata_q <= {12'h000, request_collision_flag};
        else if (reg_addr == ADDR_PPS)
          rdata_q <= {12'h000, ping_pong_state};
        else if (reg_addr == ADDR_LCA)
          rdata_q <= {12'h000, last_channel};
        else if (reg_addr == ADDR_DSADRL)
          rdata_q <= recent_sram_address[15:0];
        else if (reg_addr == ADDR_DSADRH)
          rdata_q <= {8'h00, recent_sram_address[23:16]};
      end
      for (int c = 0; c < DMAC_NCH; c++)
      begin
        if (ctrl[c][CTRL_EN_BIT] && force_bit[c] && irq_lvl[c] && !irq_prev[c])
          request_collision_flag[c] <= 1'b1;
        if (ctrl[c][CTRL_EN_BIT] && pwc_lvl[c])
          pwc_flag[c] <= 1'b1;
        // completion clears the force first so that a write in the same cycle wins
        if (state == ST_DONE && cur == 2'(c))
          force_bit[c] <= 1'b0;
        if (reg_wr && reg_addr[7] == 1'b0 && int'(reg_addr[6:5]) == c)
        begin
          unique case (reg_addr[4:2])
            REG_CTRL:
            begin
              ctrl[c] <= reg_wdata & CTRL_WMASK;
              // a fresh enable restarts from the primary buffer
              if (reg_wdata[CTRL_EN_BIT] && !ctrl[c][CTRL_EN_BIT])
              begin
                done_cnt[c] <= '0;
                offs[c] <= '0;
                ping_pong_state[c] <= 1'b0;
                second_block[c] <= 1'b0;
              end
            end
            REG_REQ:
            begin
              request_number[c] <= reg_wdata[7:0];
              if (reg_wdata[REQ_FORCE_BIT])
                force_bit[c] <= 1'b1;
            end
            REG_STAL: sta[c][15:0] <= reg_wdata;
            REG_STAH: sta[c][23:16] <= reg_wdata[7:0];
            REG_STBL: stb[c][15:0] <= reg_wdata;
            REG_STBH: stb[c][23:16] <= reg_wdata[7:0];
            REG_PAD: pad[c] <= reg_wdata;
            REG_CNT: count_field[c] <= reg_wdata[CNT_W-1:0];
          endcase
        end
        if (!ctrl[c][CTRL_EN_BIT])
          force_bit[c] <= 1'b0;
      end
      if (state == ST_DONE)
      begin
        last_channel <= {2'h0, cur};
        recent_sram_address <= sram_addr(int'(cur));
        if (ctrl[cur][CTRL_AMODE_LSB+:2] == AMODE_POSTINC)
          offs[cur] <= offs[cur] + (ctrl[cur][CTRL_SIZE_BIT] ? 24'h000001 : 24'h000002);
        // half-block point: after count/2 + 1 elements
        if (ctrl[cur][CTRL_HALF_BIT] && done_cnt[cur] == (count_field[cur] >> 1))
          channel_interrupt_flag[cur] <= 1'b1;
        if (done_cnt[cur] == count_field[cur])
        begin
          done_cnt[cur] <= '0;
          offs[cur] <= '0;
          if (!ctrl[cur][CTRL_HALF_BIT])
            channel_interrupt_flag[cur] <= 1'b1;
          if (ctrl[cur][MODE_PINGPONG_BIT])
            ping_pong_state[cur] <= !ping_pong_state[cur];
          if (ctrl[cur][MODE_ONESHOT_BIT])
          begin
            // single buffer stops now; ping-pong stops after the second block
            if (!ctrl[cur][MODE_PINGPONG_BIT] || second_block[cur])
            begin
              ctrl[cur][CTRL_EN_BIT] <= 1'b0;
              second_block[cur] <= 1'b0;
            end
            else
              second_block[cur] <= 1'b1;
          end
        end
        else
          done_cnt[cur] <= done_cnt[cur] + 14'h0001;
      end
    end
  end

  // null write: selected when the write phase goes to sram; no write is mirrored to the peripheral
  logic null_write_select;
  assign null_write_select = ctrl[cur][CTRL_NULL_WRITE_SELECT_BIT] && !ctrl[cur][CTRL_DIR_BIT];
  assign reg_rdata = rdata_q;
  // only marks the cycle; null_wr_q drives no port, so no null peripheral write is issued
  logic null_wr_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      null_wr_q <= 1'b0;
    else
      null_wr_q <= (state == ST_WRITE) && mem_gnt && null_write_select;
  end
endmodule

// *** dmac_top_assertions.sv ***
// port-level checks of the dma controller bus engine
`timescale 1ns/1ps
module dmac_top_assertions
  import dmac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_periph,
  input wire logic mem_byte,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_gnt,
  input wire logic [DMAC_NCH-1:0] channel_interrupt_flag
);
  logic [2:0] since_wr;
  logic [2:0] next_since_wr;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // saturating age of the last completed write phase
  always_comb
  begin
    next_since_wr = (since_wr == 3'h7) ? since_wr : since_wr + 3'h1;
    if (mem_req && mem_gnt && mem_we)
      next_since_wr = 3'h0;
  end
  always_ff @(posedge clk_sys)
  begin
    since_wr <= rstn ? next_since_wr : 3'h7;
  end
  AST_STALL_HOLD: assert property (
    mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("bus request changed while stalled");
  AST_READ_FIRST: assert property (
    $rose(mem_req) |-> !mem_we)
    else $error("transfer began with a write");
  AST_READ_THEN_WRITE: assert property (
    mem_req && mem_gnt && !mem_we |=> mem_req && mem_we && mem_periph != $past(mem_periph))
    else $error("write phase missing or same side as read");
  AST_WRITE_ENDS: assert property (
    mem_req && mem_gnt && mem_we |=> !mem_req)
    else $error("bus held after write phase");
  AST_SIZE_STEADY: assert property (
    mem_req && mem_gnt && !mem_we |=> mem_byte == $past(mem_byte))
    else $error("size changed inside a transfer");
  AST_IRQ_PULSE: assert property (
    channel_interrupt_flag != 4'h0 |=>
      (channel_interrupt_flag & $past(channel_interrupt_flag)) == 4'h0)
    else $error("interrupt longer than one cycle");
  AST_IRQ_CAUSE: assert property (
    channel_interrupt_flag != 4'h0 |-> since_wr < 3'h4)
    else $error("interrupt without a recent write");
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without a read strobe");
  AST_QUIET_AFTER_RESET: assert property (
    $rose(rstn) |-> !mem_req && channel_interrupt_flag == 4'h0)
    else $error("activity straight after reset");
  cover property (mem_req && !mem_gnt);
  cover property (mem_req && mem_gnt && mem_we && mem_periph);
  cover property (channel_interrupt_flag != 4'h0);
endmodule
bind dmac_top dmac_top_assertions u_chk (.clk_sys(clk_sys), .rstn(rstn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_periph(mem_periph),
  .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
  .channel_interrupt_flag(channel_interrupt_flag));

// *** testbench.sv ***
// self-checking bench for the dma controller and its bus partner
`timescale 1ns/1ps
module testbench;
  import dmac_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [7:0] lf = 8'h16;
  logic [15:0] reg_wdata = '0;
  logic [127:0] irq = '0;
  logic [127:0] wcol = '0;
  logic [23:0] pia = '0;
  logic [3:0] stall = '0;
  logic [3:0] pp = '0;
  logic [15:0] reg_rdata, mem_wdata, mem_rdata;
  logic [23:0] mem_addr;
  logic [3:0] cif;
  logic mem_req, mem_we, mem_periph, mem_byte, mem_gnt;
  logic [41:0] e;
  int failures = 0;
  int num_checks = 0;
  int nirq[4];
  dmac_top uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_irq(irq),
    .periph_wr_collision(wcol), .periph_indirect_addr(pia), .mem_req(mem_req),
    .mem_we(mem_we), .mem_periph(mem_periph), .mem_byte(mem_byte), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata),
    .channel_interrupt_flag(cif));
  dmac_mem_model mem (.clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_periph(mem_periph), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .stall(stall), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata));
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    foreach (nirq[i])
      nirq[i] += int'(cif[i]);
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] ra(input int c, input logic [2:0] i);
    return 8'(c * 32) | {3'h0, i, 2'h0};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk({9'h0, reg_rdata}, {9'h0, x});
  endtask
  task automatic getw;
    for (int t = 0; t < 80 && mem.wq.size() == 0; t++)
      @(posedge clk_sys);
    e = (mem.wq.size() > 0) ? mem.wq.pop_front() : '1;
  endtask
  task automatic cfg(input int c, input logic [15:0] ctrl, input logic [15:0] cnt);
    wr(ra(c, REG_STAL), 16'h4000);
    wr(ra(c, REG_STAH), 16'(c));
    wr(ra(c, REG_STBL), 16'h8000);
    wr(ra(c, REG_STBH), 16'(c));
    wr(ra(c, REG_PAD), 16'h0300 + 16'(c));
    wr(ra(c, REG_CNT), cnt);
    wr(ra(c, REG_CTRL), ctrl);
  endtask
  // one channel, n elements per block, each element started by the force bit
  task automatic run(input int c, input logic [15:0] ctrl, input int n, input int blocks,
    input logic [3:0] s);
    logic [24:0] sram;
    logic [24:0] pad;
    logic [15:0] m;
    logic [15:0] src;
    int n0;
    int want;
    n0 = nirq[c];
    m = ctrl[14] ? 16'h00ff : 16'hffff;
    pad = {1'b1, 8'h00, 16'h0300 + 16'(c)};
    cfg(c, ctrl, 16'(n - 1));
    stall <= s;
    for (int b = 0; b < blocks; b++)
    begin
      for (int k = 0; k < n; k++)
      begin
        sram = {1'b0, 8'(c), (b % 2 == 1 && ctrl[1]) ? 16'h8000 : 16'h4000};
        sram = ctrl[5] ? {1'b0, pia} : sram + 25'(ctrl[4] ? 0 : (ctrl[14] ? k : 2 * k));
        wr(ra(c, REG_REQ), 16'h8000);
        if (s == 4'hf)
        begin
          // long stall keeps the forced transfer in flight across the write
          wr(ra(c, REG_REQ), 16'h0000);
          rd(ra(c, REG_REQ), 16'h8000);
        end
        getw();
        chk(e[40:16], ctrl[13] ? pad : sram);
        chk({24'h0, e[41]}, {24'h0, ctrl[14]});
        src = ctrl[13] ? sram[15:0] : pad[15:0];
        chk({9'h0, e[15:0] & m}, {9'h0, (src ^ 16'ha5c3) & m});
        rd(ADDR_LCA, 16'(c));
        rd(ADDR_DSADRL, sram[15:0]);
        want = b + ((ctrl[12] ? k >= (n - 1) / 2 : k == n - 1) ? 1 : 0);
        chk(25'(nirq[c] - n0), 25'(want));
      end
    end
    if (ctrl[1])
      pp[c] = pp[c] ^ blocks[0];
    rd(ra(c, REG_REQ), 16'h0000);
    rd(ADDR_PPS, {12'h000, pp});
    rd(ra(c, REG_CTRL), ctrl[0] ? ctrl & 16'h7fff : ctrl);
    wr(ra(c, REG_CTRL), 16'h0000);
  endtask
  initial
  begin
    // a full run needs well under a thousand cycles; twenty thousand means a hang
    #(25 * 20000);
    failures++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(ADDR_LCA, 16'h000f);
    rd(ra(0, REG_CTRL), 16'h0000);
    rd(8'h98, 16'h0000);
    wr(ra(3, REG_CTRL), 16'hffff);
    rd(ra(3, REG_CTRL), 16'hf833);
    wr(ra(3, REG_CTRL), 16'h0000);
    run(0, 16'h8001, 3, 1, 4'hf);
    lf = lfsr(lf);
    pia <= {8'h00, lf, 8'h00};
    run(1, 16'hf003, 4, 2, {2'h0, lf[1:0]});
    run(2, 16'h8012, 2, 1, {2'h0, lf[3:2]});
    run(3, 16'h9020, 5, 1, {2'h0, lf[5:4]});
    // every channel waits on one shared random source
    lf = lfsr(lf);
    for (int c = 0; c < 4; c++)
    begin
      wr(ra(c, REG_REQ), {9'h000, lf[6:0]});
      cfg(c, 16'h8000, 16'h0000);
    end
    // channel 3 is forced just as the peripheral edge arrives: a request collision
    wr(ra(3, REG_REQ), {9'h100, lf[6:0]});
    irq[lf[6:0]] <= 1'b1;
    wcol[lf[6:0]] <= 1'b1;
    getw();
    chk(e[40:16], {1'b0, 8'h03, 16'h4000});
    for (int c = 0; c < 4; c++)
    begin
      getw();
      chk(e[40:16], {1'b0, 8'(c), 16'h4000});
    end
    rd(ADDR_LCA, 16'h0003);
    rd(ADDR_PWC, 16'h000f);
    rd(ADDR_RQC, 16'h0008);
    @(posedge clk_sys);
    irq <= '0;
    wcol <= '0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(ADDR_LCA, 16'h000f);
    rd(ADDR_PWC, 16'h0000);
    rd(ADDR_RQC, 16'h0000);
    summarize();
  end
endmodule
